/* common/rrr_defines.vh */
`ifndef RRR_DEFINES_VH
`define RRR_DEFINES_VH

// ==========================================
// Register map
`define RRR_OFF_CTRL 8'h00
`define RRR_OFF_MODE 8'h04
`define RRR_OFF_NWIN 8'h08
`define RRR_OFF_STAT 8'h0c
`define RRR_WIN_SEL 2'b01
`define RRR_CTRL_START 0
`define RRR_MODE_REVX 6
`define RRR_MODE_REVY 7
`define RRR_MODE_SUB 1:0
`define RRR_RST_NWIN 3'h1
`define RRR_RST_YEND 11'h001
`define RRR_RST_XK 7'h01

// ==========================================
// Subsampling selections
`define RRR_SUB_NONE 2'b00
`define RRR_SUB_COLOR 2'b01
`define RRR_SUB_MONO 2'b10
`define RRR_SUB_RSVD 2'b11

// ==========================================
// Sync channel codes
`define RRR_SY_IDLE 10'h000
`define RRR_SY_FS 10'h059
`define RRR_SY_LS 10'h056
`define RRR_SY_FE 10'h05a
`define RRR_SY_LE 10'h055
`define RRR_SY_GBC 10'h0a9
`define RRR_SY_CRC 10'h0a6
`define RRR_SY_FPN 10'h13c
`define RRR_SY_D 10'h193

// ==========================================
// Geometry
`define RRR_COLS_SLOT 24
`define RRR_COLS_GRP 48
`define RRR_NSLOT 7'd54
`define RRR_NGRP 7'd27
`define RRR_ODD_LAST 23
`define RRR_COLOR_ODD 47
`define RRR_MONO_B 46

// ==========================================
// Sequencer states
`define RRR_ST_IDLE 3'd0
`define RRR_ST_LS 3'd1
`define RRR_ST_SLOT 3'd2
`define RRR_ST_CRC 3'd3
`define RRR_ST_LE 3'd4

`endif

/* rtl/rrr_readout.v */
`timescale 1ns/100ps
`include "rrr_defines.vh"

module rrr_readout #(
    parameter NWIN = 4,
    parameter NCH = 12,
    parameter CW = 11
) (
    input wire pclk, // Bus and pixel clock
    input wire presetn, // Async reset, low active
    input wire psel, // APB select
    input wire penable, // APB enable
    input wire pwrite, // APB direction
    input wire [7:0] paddr, // APB byte address
    input wire [31:0] pwdata, // APB write data
    output reg [31:0] prdata_q, // APB read data
    output reg pready_q, // APB ready
    output reg pslverr_q, // APB error
    output reg [NCH*CW-1:0] ch_col_q, // Column index per channel
    output reg ch_valid_q, // Channels carry pixels
    output reg [9:0] sync_q, // Sync channel word
    output reg [10:0] line_q, // Output line number
    output reg [10:0] row_addr_q, // Array row being read
    output reg busy_q // Frame in progress
);

    // ==========================================
    // Registers
    reg [10:0] ys_q [0:NWIN-1];
    reg [5:0] xs_q [0:NWIN-1];
    reg [10:0] ye_q [0:NWIN-1];
    reg [6:0] xk_q [0:NWIN-1];
    reg [7:0] sequencer_mode_word4_q;
    reg [2:0] nwin_q;
    reg start_q;
    reg [2:0] st_q;
    reg dummy_q;
    reg [1:0] win_q;
    reg [10:0] ln_q;
    reg [6:0] pos_q;
    reg half_q;
    integer i;

    wire acc = psel & penable & pready_q;
    wire wr = acc & pwrite;
    wire win_hit = (paddr[7:6] == `RRR_WIN_SEL) && ({1'b0, paddr[5:4]} < NWIN);
    wire [1:0] aw = paddr[5:4];
    wire revx = sequencer_mode_word4_q[`RRR_MODE_REVX];
    wire revy = sequencer_mode_word4_q[`RRR_MODE_REVY];
    wire [1:0] sub_cfg = sequencer_mode_word4_q[`RRR_MODE_SUB];
    // Reserved subsample code falls back to plain readout; mapping and slot count stay consistent
    wire [1:0] sub = (dummy_q || sub_cfg == `RRR_SUB_RSVD) ? `RRR_SUB_NONE : sub_cfg;

    // Plain registers decode on the full byte address
    wire wr_ctrl = wr && !win_hit && paddr == `RRR_OFF_CTRL;
    wire wr_mode = wr && !win_hit && paddr == `RRR_OFF_MODE;
    wire wr_nwin = wr && !win_hit && paddr == `RRR_OFF_NWIN;

    // ==========================================
    // APB decode
    reg [31:0] rd;
    reg err;
    always @* begin
        rd = 32'h0000_0000;
        err = 1'b0;
        if (win_hit) begin
            case (paddr[3:2])
                2'd0: rd = {21'h000000, ys_q[aw]};
                2'd1: rd = {26'h0000000, xs_q[aw]};
                2'd2: rd = {21'h000000, ye_q[aw]};
                default: rd = {25'h0000000, xk_q[aw]};
            endcase
        end else begin
            case (paddr)
                `RRR_OFF_CTRL: rd = 32'h0000_0000;
                `RRR_OFF_MODE: rd = {24'h000000, sequencer_mode_word4_q};
                `RRR_OFF_NWIN: rd = {29'h00000000, nwin_q};
                // Bit 2 is spare and reads zero
                `RRR_OFF_STAT: rd = {13'h0000, ln_q, win_q, st_q, 1'b0, dummy_q, busy_q};
                default: err = 1'b1;
            endcase
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
            pslverr_q <= 1'b0;
            start_q <= 1'b0;
            sequencer_mode_word4_q <= 8'h00;
            nwin_q <= `RRR_RST_NWIN;
            for (i = 0; i < NWIN; i = i + 1) begin
                ys_q[i] <= 11'h000;
                xs_q[i] <= 6'h00;
                ye_q[i] <= `RRR_RST_YEND;
                xk_q[i] <= `RRR_RST_XK;
            end
        end else begin
            // No wait state: answer computed in setup, shown in the first access cycle
            pready_q <= psel & ~penable;
            prdata_q <= (psel & ~penable & ~pwrite) ? rd : 32'h0000_0000;
            pslverr_q <= psel & ~penable & err;
            // Start is a one-cycle pulse; the sequencer drops it unless idle
            start_q <= wr_ctrl && pwdata[`RRR_CTRL_START];
            if (wr_mode)
                sequencer_mode_word4_q <= pwdata[7:0];
            // A count of zero windows loads the reset count of one instead
            if (wr_nwin)
                nwin_q <= (pwdata[2:0] == 3'h0) ? `RRR_RST_NWIN : pwdata[2:0];
            if (wr && win_hit) begin
                case (paddr[3:2])
                    2'd0: ys_q[aw] <= pwdata[10:0];
                    2'd1: xs_q[aw] <= pwdata[5:0];
                    2'd2: ye_q[aw] <= pwdata[10:0];
                    default: xk_q[aw] <= pwdata[6:0];
                endcase
            end
        end
    end

    // ==========================================
    // Row geometry of the active window
    reg [6:0] nu, xsu, kern, last_in, cnt, len, unit;
    reg incl;
    reg [10:0] nlines;
    always @* begin
        nu = (sub == `RRR_SUB_NONE) ? `RRR_NSLOT : `RRR_NGRP;
        xsu = (sub == `RRR_SUB_NONE) ? {1'b0, xs_q[win_q]} : {2'b00, xs_q[win_q][5:1]};
        kern = (xk_q[win_q] == 7'h00) ? 7'h01 : xk_q[win_q];
        if (dummy_q) begin
            xsu = 7'h00;
            kern = nu;
        end
        // Windows running past the last slot are clipped there
        if (xsu >= nu)
            xsu = nu - 7'h01;
        last_in = (xsu + kern > nu) ? nu - 7'h01 : xsu + kern - 7'h01;
        cnt = last_in - xsu + 7'h01;
        incl = (last_in == nu - 7'h01);
        // Reference slot appended only when outside the window
        len = cnt + {6'h00, ~incl};
        // Reverse X: the reference slot leads, then the window backwards
        if (revx && !dummy_q) begin
            if (!incl && pos_q == 7'h00)
                unit = nu - 7'h01;
            else
                unit = last_in - (pos_q - {6'h00, ~incl});
        end else begin
            unit = (pos_q == cnt) ? nu - 7'h01 : xsu + pos_q;
        end
        nlines = ye_q[win_q] - ys_q[win_q] + 11'h001;
    end

    // ==========================================
    // Column remap for one half slot
    reg [NCH*CW-1:0] cols;
    // Integer arithmetic keeps the formulas plain; only CW bits reach the port
    integer c, base, col;
    always @* begin
        cols = {NCH*CW{1'b0}};
        base = 0;
        col = 0;
        for (c = 0; c < NCH; c = c + 1) begin
            case (sub)
                `RRR_SUB_COLOR: begin
                    base = unit * `RRR_COLS_GRP;
                    if (c % 2 == 0)
                        col = base + 2 * c + half_q;
                    else
                        col = base + `RRR_COLOR_ODD - 2 * c - half_q;
                end
                `RRR_SUB_MONO: begin
                    base = unit * `RRR_COLS_GRP;
                    col = half_q ? base + `RRR_MONO_B - 2 * c : base + 2 * c;
                end
                default: begin
                    base = unit * `RRR_COLS_SLOT;
                    if (unit[0] == 1'b0)
                        col = base + 2 * c + half_q;
                    else
                        col = base + `RRR_ODD_LAST - 2 * c - half_q;
                end
            endcase
            cols[c*CW +: CW] = col[CW-1:0];
        end
    end

    // ==========================================
    // Sequencer
    wire last_line = (ln_q == nlines - 11'h001);
    wire last_win = ({1'b0, win_q} == nwin_q - 3'h1) || ({1'b0, win_q} == NWIN - 1);
    wire first_line = (ln_q == 11'h000);
    reg [9:0] slot_sync;
    always @* begin
        if (dummy_q)
            slot_sync = `RRR_SY_FPN;
        else if (unit == nu - 7'h01 && !incl)
            slot_sync = `RRR_SY_GBC;
        else
            slot_sync = `RRR_SY_D;
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= `RRR_ST_IDLE;
            dummy_q <= 1'b0;
            win_q <= 2'd0;
            ln_q <= 11'h000;
            pos_q <= 7'h00;
            half_q <= 1'b0;
            busy_q <= 1'b0;
            ch_col_q <= {NCH*CW{1'b0}};
            ch_valid_q <= 1'b0;
            sync_q <= `RRR_SY_IDLE;
            line_q <= 11'h000;
            row_addr_q <= 11'h000;
        end else begin
            ch_valid_q <= 1'b0;
            ch_col_q <= {NCH*CW{1'b0}};
            case (st_q)
                `RRR_ST_IDLE: begin
                    sync_q <= `RRR_SY_IDLE;
                    busy_q <= start_q;
                    if (start_q) begin
                        dummy_q <= 1'b1;
                        win_q <= 2'd0;
                        ln_q <= 11'h000;
                        st_q <= `RRR_ST_LS;
                    end
                end
                `RRR_ST_LS: begin
                    sync_q <= (!dummy_q && first_line) ? `RRR_SY_FS : `RRR_SY_LS;
                    line_q <= ln_q;
                    // Reverse Y walks down from y_end so line numbers still rise
                    if (dummy_q)
                        row_addr_q <= 11'h000;
                    else
                        row_addr_q <= revy ? ye_q[win_q] - ln_q : ys_q[win_q] + ln_q;
                    pos_q <= 7'h00;
                    half_q <= 1'b0;
                    st_q <= `RRR_ST_SLOT;
                end
                `RRR_ST_SLOT: begin
                    sync_q <= slot_sync;
                    ch_col_q <= cols;
                    ch_valid_q <= 1'b1;
                    half_q <= ~half_q;
                    if (half_q) begin
                        pos_q <= pos_q + 7'h01;
                        if (pos_q == len - 7'h01)
                            st_q <= `RRR_ST_CRC;
                    end
                end
                `RRR_ST_CRC: begin
                    sync_q <= `RRR_SY_CRC;
                    st_q <= `RRR_ST_LE;
                end
                `RRR_ST_LE: begin
                    st_q <= `RRR_ST_LS;
                    // The dummy line never closes a frame: FS and FE belong to windows
                    sync_q <= (!dummy_q && last_line) ? `RRR_SY_FE : `RRR_SY_LE;
                    if (dummy_q) begin
                        dummy_q <= 1'b0;
                        ln_q <= 11'h000;
                    end else if (!last_line) begin
                        ln_q <= ln_q + 11'h001;
                    end else if (last_win) begin
                        st_q <= `RRR_ST_IDLE;
                        busy_q <= 1'b0;
                    end else begin
                        win_q <= win_q + 2'd1;
                        ln_q <= 11'h000;
                    end
                end
                default: st_q <= `RRR_ST_IDLE;
            endcase
        end
    end

endmodule

/* testbench/rrr_readout_props.sv */
`timescale 1ns/100ps

// ==========
// Checker on the top ports
module rrr_readout_props #(
    parameter NCH = 12,
    parameter CW = 11
) (
    input wire pclk, // Clock
    input wire presetn, // Reset
    input wire psel, // Select
    input wire penable, // Enable
    input wire pready_q, // Ready
    input wire pslverr_q, // Error
    input wire [NCH*CW-1:0] ch_col_q, // Columns
    input wire ch_valid_q, // Valid
    input wire [9:0] sync_q, // Sync
    input wire [10:0] line_q, // Line
    input wire busy_q // Busy
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire [CW-1:0] top_col = ch_col_q[NCH*CW-1 -: CW];
    chk_ready_next: assert property (psel && !penable |=> pready_q) else $error("ready late");
    chk_ready_pulse: assert property (pready_q |=> !pready_q) else $error("ready held");
    chk_err_ready: assert property (pslverr_q |-> pready_q) else $error("error alone");
    chk_crc_close: assert property (sync_q == 10'h0a6 |->
        (!ch_valid_q && ch_col_q == '0) ##1 (sync_q == 10'h055 || sync_q == 10'h05a)) else $error("bad crc");
    chk_crc_follow: assert property ($fell(ch_valid_q) |-> sync_q == 10'h0a6) else $error("no crc");
    chk_data_code: assert property (ch_valid_q |->
        sync_q inside {10'h193, 10'h0a9, 10'h13c}) else $error("bad code");
    chk_half_pair: assert property (sync_q inside {10'h056, 10'h059} |=> ch_valid_q [*2])
        else $error("half missing");
    chk_ref_slot: assert property (sync_q == 10'h0a9 |->
        ch_valid_q && top_col inside {11'd1273, 11'd1272}) else $error("bad ref slot");
    chk_line_up: assert property (busy_q && $past(busy_q) && line_q != $past(line_q) |->
        line_q == $past(line_q) + 11'd1 || line_q == 11'd0) else $error("line down");
endmodule

bind rrr_readout rrr_readout_props #(.NCH(NCH), .CW(CW)) rrr_readout_props_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready_q(pready_q),
    .pslverr_q(pslverr_q), .ch_col_q(ch_col_q), .ch_valid_q(ch_valid_q), .sync_q(sync_q),
    .line_q(line_q), .busy_q(busy_q));

/* testbench/rrr_receiver.sv */
`timescale 1ns/100ps

// ==========
// Receiver tallies; line tallies hold the last line
module rrr_receiver (
    input wire pclk, // Clock
    input wire presetn, // Reset
    input wire clr, // Clear
    input wire [9:0] sync, // Sync
    input wire valid, // Valid
    input wire [131:0] cols, // Columns
    output reg [7:0] n_fs, // Frames
    output reg [7:0] n_fpn, // Dummy words
    output reg [7:0] n_gbc, // Ref words
    output reg [7:0] n_word, // Pixel words
    output reg [131:0] first_w, // First word
    output reg [131:0] last_w // Last word
);
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {n_fs, n_fpn, n_gbc, n_word} <= 32'h0;
        end else if (clr) begin
            {n_fs, n_fpn, n_gbc, n_word} <= 32'h0;
        end else begin
            n_fs <= n_fs + {7'h0, sync == 10'h059};
            if (sync == 10'h059 || sync == 10'h056) begin
                {n_gbc, n_word} <= 16'h0;
            end
            if (valid && sync == 10'h13c) begin
                n_fpn <= n_fpn + 8'h01;
            end
            if (valid && sync != 10'h13c) begin
                if (n_word == 8'h00) begin
                    first_w <= cols;
                end
                last_w <= cols;
                n_word <= n_word + 8'h01;
                n_gbc <= n_gbc + {7'h0, sync == 10'h0a9};
            end
        end
    end
endmodule

/* testbench/test_rrr_readout.sv */
`timescale 1ns/100ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; $display("unexpected %0t %0h", $time, g); end end

module test_rrr_readout;
    typedef struct packed {
        logic [7:0] md; logic [5:0] xs; logic [6:0] xk;
        logic [10:0] f0, f1, lc; logic [7:0] wd, gb;
    } rrr_row_t;
    reg pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, clr = 1'b0, er;
    reg [7:0] paddr = 8'h00;
    reg [31:0] pwdata = 32'h0, rd;
    reg [10:0] fs_row, fe_line;
    wire [31:0] prdata_q;
    wire pready_q, pslverr_q, ch_valid_q, busy_q;
    wire [131:0] ch_col_q, first_w, last_w;
    wire [9:0] sync_q;
    wire [10:0] line_q, row_addr_q;
    wire [7:0] n_fs, n_fpn, n_gbc, n_word;
    integer n_mismatch = 0, tests_run = 0, cyc = 0, i;
    rrr_row_t r;
    rrr_row_t rows [0:6];
    rrr_readout rrr_readout_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_q(prdata_q), .pready_q(pready_q),
        .pslverr_q(pslverr_q), .ch_col_q(ch_col_q), .ch_valid_q(ch_valid_q), .sync_q(sync_q),
        .line_q(line_q), .row_addr_q(row_addr_q), .busy_q(busy_q));
    rrr_receiver rrr_receiver_inst (.pclk(pclk), .presetn(presetn), .clr(clr), .sync(sync_q),
        .valid(ch_valid_q), .cols(ch_col_q), .n_fs(n_fs), .n_fpn(n_fpn), .n_gbc(n_gbc),
        .n_word(n_word), .first_w(first_w), .last_w(last_w));
    always #5 pclk = ~pclk;
    // ==========
    // Timeout and frame-start row capture
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (sync_q === 10'h059) begin
            fs_row <= row_addr_q;
        end
        if (sync_q === 10'h05a) begin
            fe_line <= line_q;
        end
        if (cyc == 6000) begin
            n_mismatch++;
            stop_test;
        end
    end
    task stop_test;
        $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready_q !== 1'b1) @(posedge pclk);
        rd = prdata_q;
        er = pslverr_q;
        {psel, penable} <= 2'b00;
    endtask
    task rchk(input logic [7:0] a, input logic [31:0] d, input logic e);
        apb(1'b0, a, 32'h0);
        `CHK(rd, d)
        `CHK(er, e)
    endtask
    // Start, then wait out the frame
    task run(input logic c);
        clr <= c;
        @(posedge pclk);
        clr <= 1'b0;
        apb(1'b1, 8'h00, 32'h1);
        repeat (3) @(posedge pclk);
        while (busy_q === 1'b1) @(posedge pclk);
    endtask
    initial begin
        rows[0] = {8'h00, 6'd0, 7'd2, 11'd0, 11'd2, 11'd1294, 8'd6, 8'd2};
        rows[1] = {8'h00, 6'd1, 7'd1, 11'd47, 11'd45, 11'd1294, 8'd4, 8'd2};
        rows[2] = {8'h00, 6'd52, 7'd2, 11'd1248, 11'd1250, 11'd1294, 8'd4, 8'd0};
        rows[3] = {8'h00, 6'd53, 7'd3, 11'd1295, 11'd1293, 11'd1294, 8'd2, 8'd0};
        rows[4] = {8'h40, 6'd0, 7'd1, 11'd1295, 11'd1293, 11'd1, 8'd4, 8'd2};
        rows[5] = {8'h01, 6'd2, 7'd1, 11'd48, 11'd93, 11'h7ff, 8'hff, 8'hff};
        rows[6] = {8'h02, 6'd52, 7'd1, 11'd1248, 11'd1250, 11'h7ff, 8'hff, 8'hff};
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rchk(8'h04, 32'h0, 1'b0);
        rchk(8'h08, 32'h1, 1'b0);
        rchk(8'h7c, 32'h1, 1'b0);
        rchk(8'h80, 32'h0, 1'b1);
        $display("register test done");
        for (i = 0; i < 7; i++) begin
            r = rows[i];
            apb(1'b1, 8'h04, {24'h0, r.md});
            apb(1'b1, 8'h44, {26'h0, r.xs});
            apb(1'b1, 8'h4c, {25'h0, r.xk});
            run(1'b1);
            `CHK(first_w[10:0], r.f0)
            `CHK(first_w[21:11], r.f1)
            if (r.wd != 8'hff) begin
                `CHK(last_w[10:0], r.lc)
                `CHK(n_word, r.wd)
                `CHK(n_gbc, r.gb)
            end
            $display("row %0d done", i);
        end
        apb(1'b1, 8'h04, 32'h0);
        apb(1'b1, 8'h08, 32'h2);
        apb(1'b1, 8'h54, 32'd53);
        run(1'b1);
        `CHK(n_fs, 8'd2)
        `CHK(n_fpn, 8'd108)
        `CHK(n_gbc, 8'd0)
        $display("multi test done");
        apb(1'b1, 8'h08, 32'h1);
        apb(1'b1, 8'h04, 32'h80);
        apb(1'b1, 8'h40, 32'h1);
        apb(1'b1, 8'h48, 32'h3);
        apb(1'b1, 8'h00, 32'h1);
        run(1'b0);
        repeat (4) @(posedge pclk);
        `CHK(busy_q, 1'b0)
        `CHK(n_fs, 8'd3)
        `CHK(fs_row, 11'd3)
        `CHK(fe_line, 11'd2)
        rchk(8'h0c, 32'h200, 1'b0);
        apb(1'b1, 8'h00, 32'h1);
        repeat (20) @(posedge pclk);
        presetn <= 1'b0;
        @(posedge pclk);
        `CHK(sync_q, 10'h000)
        presetn <= 1'b1;
        rchk(8'h04, 32'h0, 1'b0);
        $display("reset test done");
        stop_test;
    end
endmodule
